// ---- test/lbps_host.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// host model: drives the command line
// ------------------------------------------------------------
module lbps_host (
  // clock
  input wire logic clk,
  // command line
  output logic cmd_in
);
  // starts low so the block sits idle out of reset
  initial cmd_in = 1'b0;
  // level change lands just after an edge and is held until the next call
  task automatic level(input logic lvl);
    cmd_in <= lvl;
  endtask
  // high burst, then low; a slow host simply passes a larger count
  task automatic blip(input int n);
    cmd_in <= 1'b1;
    repeat (n) @(posedge clk);
    cmd_in <= 1'b0;
  endtask
endmodule

// ---- test/lbps_top_test.sv ----
`timescale 1ns/10ps
module lbps_top_test;
  import lbps_pkg::*;
  // ------------------------------------------------------------
  // signals and scoreboard
  // ------------------------------------------------------------
  typedef struct {int len; int tol; logic red;} lbps_run_t;
  localparam int ON_C = 32'h1f4; // shortened on unit in cycles
  localparam int TOL = 32'h8; // slack for sync and state hops
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd;
  logic current_set_resistor = 1'b0; // no external resistor at first edge
  lbps_bus_t bus = '0;
  logic [7:0] rdata;
  logic led, red, int_ref;
  logic [1:0] isel;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int run_len = 0;
  int runs_seen = 0;
  integer seed = 32'ha4863947;
  logic run_red;
  logic rd_seen = 1'b0;
  logic mon_on = 1'b1; // off in mirror, where every toggle is a run
  logic [4:0] hist;
  logic [7:0] exp_rst [8] = '{8'h55, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rq[$]; // expected read data
  lbps_run_t eq[$]; // expected led high runs, oldest first
  lbps_run_t e;
  // short counts keep the run near 80k cycles
  lbps_top #(.LOW_IDLE_CYC_P(32'h14), .ARM_HIGH_CYC_P(32'h14), .INIT_PULSE_CYC_P(32'h4e20),
    .ON_UNIT_CYC_P(32'h1f4), .OFF_UNIT_CYC_P(32'h5dc), .PWM_TICK_CYC_P(12'h001)) uut (
    .CLK(clk), .NRST(nrst), .CMD_IN(cmd), .CURRENT_SET_RESISTOR_PRESENT(current_set_resistor),
    .REG_BUS(bus), .REG_RDATA(rdata), .LED_DRIVE_OUTPUT(led), .CURRENT_REDUCED(red),
    .FULL_SCALE_CURRENT_SELECT(isel), .USE_INTERNAL_REF(int_ref));
  lbps_host host (.clk(clk), .cmd_in(cmd));
  // 250 mhz
  always #2 clk = ~clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one-cycle strobes, then a quiet edge so no signal is driven twice at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= {2'b00, 3'($random(seed)), 8'($random(seed))};
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    bus <= {1'b0, 1'b1, a, 8'($random(seed))};
    @(posedge clk);
    bus <= {2'b00, 3'($random(seed)), 8'($random(seed))};
    @(posedge clk);
  endtask
  task automatic want(input int n, input int len, input int tol, input logic r);
    repeat (n) eq.push_back(lbps_run_t'{len, tol, r});
  endtask
  // bounded wait for all noted runs to show up
  task automatic drain(input int lim);
    for (int i = 0; i < lim && eq.size() != 0; i++) @(posedge clk);
    check(32'(eq.size()), 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // monitor: read data one cycle after the strobe, led runs at their end
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_seen) begin
      check(32'(rdata), 32'(rq.pop_front()));
    end
    rd_seen <= bus.rd;
    if (led === 1'b1) begin
      run_len <= run_len + 1;
      // sampled a few cycles in, once the current range has settled
      if (run_len == 3) begin
        run_red <= red;
      end
    end else if (run_len != 0) begin
      run_len <= 0;
      runs_seen++;
      if (mon_on && eq.size() == 0) begin
        check(32'(run_len), 32'h0);
      end else if (mon_on) begin
        e = eq.pop_front();
        check(32'((run_len - e.len) <= e.tol && (e.len - run_len) <= e.tol), 32'h1);
        check(32'(run_red), 32'(e.red));
      end
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h186a0) begin
      bad_count++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(32'(int_ref), 32'h0);
    foreach (exp_rst[i]) begin
      rd(3'(i), exp_rst[i]);
    end
    wr(3'h5, 8'hff);
    wr(3'h4, 8'hff);
    rd(3'h5, 8'h00);
    rd(3'h4, 8'hc7);
    for (int i = 0; i < 4; i++) begin
      wr(3'h4, 8'(i << 6));
      @(posedge clk);
      check(32'(isel), 32'(i));
    end
    // jump ramps, one on unit, one off unit
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h11);
    wr(3'h4, 8'h00);
    check(32'(led), 32'h0);
    // default mode, short command: initial pulse only
    want(1, ON_C, TOL, 1'b0);
    host.blip(100);
    drain(1000);
    idle(3000);
    check(32'(int_ref), 32'h1);
    current_set_resistor <= 1'b1;
    // default mode, held command: pattern after the initial window
    host.level(1'b1);
    want(1, ON_C, TOL, 1'b0);
    idle(15000);
    check(32'(runs_seen), 32'h2);
    want(3, ON_C, TOL, 1'b0);
    drain(12000);
    host.level(1'b0);
    idle(3000);
    check(32'(led), 32'h0);
    check(32'(int_ref), 32'h1);
    // repeat mode with the second pulse enabled
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h31);
    wr(3'h4, 8'h02);
    want(1, ON_C, TOL, 1'b0);
    want(1, 3 * ON_C, TOL, 1'b0);
    want(1, ON_C, TOL, 1'b0);
    host.level(1'b1);
    drain(9000);
    host.level(1'b0);
    idle(2000);
    // second pulse off time zero disables it; slow bit doubles times
    wr(3'h3, 8'h30);
    wr(3'h4, 8'h06);
    want(2, 2 * ON_C, TOL, 1'b0);
    host.level(1'b1);
    drain(9000);
    host.level(1'b0);
    idle(200);
    // one-shot: short burst refused, armed burst plays through
    wr(3'h3, 8'h31);
    wr(3'h4, 8'h03);
    host.blip(10);
    idle(200);
    want(1, ON_C, TOL, 1'b0);
    host.blip(30);
    drain(1000);
    idle(2500);
    want(3, ON_C, TOL, 1'b0);
    host.level(1'b1);
    drain(8000);
    host.level(1'b0);
    idle(2500);
    // rising ramp at rate one, aborted after step 8
    wr(3'h0, 8'h10);
    wr(3'h4, 8'h02);
    for (int i = 1; i < 9; i++) begin
      want(1, 32'(BRIGHT_ON_US[i]), 0, i < 8);
    end
    host.level(1'b1);
    drain(34000);
    host.level(1'b0);
    idle(200);
    check(32'(led), 32'h0);
    // mirror with random command chatter
    wr(3'h4, 8'h01);
    mon_on <= 1'b0;
    host.level(1'b1);
    idle(10);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      host.level(1'($random(seed)));
      #1;
      hist = {hist[3:0], cmd};
      if (i > 8) begin
        check(32'(led), 32'(hist[3]));
      end
    end
    summarize();
  end
endmodule

// ---- verilog/lbps_pkg.sv ----
package lbps_pkg;
  // ------------------------------------------------------------
  // clock and time base
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;               // 250 MHz core clock
  localparam int CLK_PER_US = 1000 / CLK_PERIOD_NS;
  localparam int LOW_IDLE_US = 200;               // low time back to idle
  localparam int ARM_HIGH_US = 200;               // one-shot arming high time
  localparam int INIT_PULSE_MS = 1700;            // initial pulse window
  localparam int ON_UNIT_US = 106600;             // on-time unit 106.6 ms
  localparam int OFF_UNIT_US = 320000;            // off-time unit 320 ms
  localparam int PWM_PERIOD_US = 3333;            // brightness pwm period
  // derived cycle counts (all exact at 4 ns)
  localparam int LOW_IDLE_CYC = LOW_IDLE_US * CLK_PER_US;
  localparam int ARM_HIGH_CYC = ARM_HIGH_US * CLK_PER_US;
  localparam int INIT_PULSE_CYC = INIT_PULSE_MS * 1000 * CLK_PER_US;
  localparam int ON_UNIT_CYC = ON_UNIT_US * CLK_PER_US;
  localparam int OFF_UNIT_CYC = OFF_UNIT_US * CLK_PER_US;
  localparam logic [11:0] PWM_LAST_US = 12'(PWM_PERIOD_US - 1);

  // ------------------------------------------------------------
  // register offsets, resets and fields
  // ------------------------------------------------------------
  localparam logic [2:0] REG_RAMP1 = 3'h0;        // first_ramp_rate
  localparam logic [2:0] REG_FIRST_PULSE = 3'h1;       // first_pulse
  localparam logic [2:0] REG_RAMP2 = 3'h2;        // second_ramp_rate
  localparam logic [2:0] REG_SECOND_PULSE = 3'h3;       // second_pulse
  localparam logic [2:0] REG_CTRL = 3'h4;         // control
  localparam logic [2:0] REG_STATUS = 3'h5;       // read-only status
  localparam logic [7:0] RAMP1_RST = 8'h55;
  localparam logic [7:0] FIRST_PULSE_RST = 8'h55;
  localparam logic [7:0] RAMP2_RST = 8'h55;
  localparam logic [7:0] SECOND_PULSE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hc7;      // bits 5:3 reserved
  localparam int HI_NIB = 4;                      // rise rate / on count
  localparam int ISEL_LSB = 6;                    // full_scale_current_select
  localparam int SLOW_BIT = 2;
  localparam logic [4:0] STEP_MAX = 5'h1f;
  localparam logic [4:0] STEP_REDUCED_LIM = 5'h08;

  // brightness table, on-time per step in microseconds
  localparam logic [11:0] BRIGHT_ON_US [32] = '{
    12'h000, 12'h00d, 12'h041, 12'h09c, 12'h12b, 12'h1e2, 12'h2cc, 12'h3f8,
    12'h0a9, 12'h0dd, 12'h111, 12'h153, 12'h1a1, 12'h1ef, 12'h24a, 12'h2a5,
    12'h30d, 12'h375, 12'h3eb, 12'h46d, 12'h4fc, 12'h58b, 12'h61b, 12'h6c4,
    12'h76d, 12'h816, 12'h8da, 12'h99d, 12'ha6d, 12'hb3e, 12'hc1b, 12'hd05};

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00, MODE_MIRROR = 2'b01,
    MODE_REPEAT = 2'b10, MODE_ONESHOT = 2'b11} lbps_mode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ARM = 3'b001, S_RISE = 3'b010, S_ON = 3'b011,
    S_FALL = 3'b100, S_OFF = 3'b101, S_WAIT = 3'b110,
    S_MIRROR = 3'b111} lbps_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } lbps_bus_t;
  typedef struct packed {
    logic [11:0] data;
  } lbps_rom_t;
endpackage

// ---- verilog/lbps_rom.sv ----
`timescale 1ns/10ps
module lbps_rom (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // lookup
  input wire logic [4:0] ADDR,
  output logic [11:0] DATA
);
  import lbps_pkg::*;

  lbps_rom_t st; // registered read data
  lbps_rom_t next_st; // next read data

  // --------------------------------------------
  // table lookup, one cycle of latency
  // --------------------------------------------
  always_comb begin
    next_st = st;
    next_st.data = BRIGHT_ON_US[ADDR];
  end

  // register stage
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign DATA = st.data;
endmodule

// ---- verilog/lbps_top.sv ----
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - idle, led off, until command rising edge
// - default mode short command: one pulse only
// - command held past 1.7 s: repeating pattern
// - command low over 200 us returns idle, except in mirror mode, during a one-shot pattern and during the initial pulse
// - mode bits override default command behaviour
// - repeat mode loops first and second pulse while high
// - pattern starts first pulse; empty second skipped
// - reset values give default first pulse
// - ramps step table; rate per pulse
// - mirror mode: led equals command level
// - mode bits decode default, mirror, repeat, one-shot
// - one-shot arms after 200 us high
// - one-shot ignores command during pulse
// - one-shot replays while command still high
// - pwm period 3333 us, log table
// - steps below 8 run reduced current
// - control bits 7:6 select full-scale current
// - first rising edge samples current resistor presence
// - registers default to pattern, host rewrites
// - ramp 31 steps times rate; zero jumps
// - on/off time units scaled by slow bit
// - zero on-time falls at once; second disabled
module lbps_top #(
  parameter logic [31:0] LOW_IDLE_CYC_P = 32'(lbps_pkg::LOW_IDLE_CYC),
  parameter logic [31:0] ARM_HIGH_CYC_P = 32'(lbps_pkg::ARM_HIGH_CYC),
  parameter logic [31:0] INIT_PULSE_CYC_P = 32'(lbps_pkg::INIT_PULSE_CYC),
  parameter logic [31:0] ON_UNIT_CYC_P = 32'(lbps_pkg::ON_UNIT_CYC),
  parameter logic [31:0] OFF_UNIT_CYC_P = 32'(lbps_pkg::OFF_UNIT_CYC),
  parameter logic [11:0] PWM_TICK_CYC_P = 12'(lbps_pkg::CLK_PER_US)
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // pins
  input wire logic CMD_IN,
  input wire logic CURRENT_SET_RESISTOR_PRESENT,
  // register port
  input wire lbps_pkg::lbps_bus_t REG_BUS,
  output logic [7:0] REG_RDATA,
  // led drive
  output logic LED_DRIVE_OUTPUT,
  output logic CURRENT_REDUCED,
  output logic [1:0] FULL_SCALE_CURRENT_SELECT,
  output logic USE_INTERNAL_REF
);
  import lbps_pkg::*;

  // ------------------------------------------------------------
  // module state, one packed struct
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ramp1;       // rise/fall rate, first pulse
    logic [7:0] first_pulse;      // on/off counts, first pulse
    logic [7:0] ramp2;       // rise/fall rate, second pulse
    logic [7:0] second_pulse;      // on/off counts, second pulse
    logic [7:0] ctrl;        // current select, slow, mode
    logic [7:0] rdata;       // read data, one cycle after strobe
    logic cmd_meta;          // synchroniser stage one
    logic cmd_sync;          // synchronised command level
    logic cmd_prev;          // for edge detection
    logic current_set_resistor_meta;
    logic current_set_resistor_sync;
    logic first_seen;        // first rising edge already taken
    logic internal_ref;
    lbps_state_t state;
    logic sel2;              // playing the second pulse
    logic init;              // initial pulse of default mode
    logic oneshot;           // pattern started in one-shot mode
    logic [4:0] step;        // brightness step
    logic [3:0] rate_cnt;    // periods spent on this step
    logic [31:0] tmr;        // cycles within a time unit
    logic [4:0] units;       // elapsed time units
    logic [31:0] hi_cnt;     // cycles command high, saturating
    logic [31:0] low_cnt;    // cycles command low, saturating
    logic [11:0] pre_cnt;    // microsecond prescaler
    logic [11:0] us_cnt;     // position in pwm period
    logic led;
    logic reduced;
  } lbps_core_t;

  lbps_core_t st; // current state
  lbps_core_t next_st; // next state
  logic [11:0] on_us; // on-time of the current step
  logic tick; // one microsecond elapsed
  logic period_end; // last tick of a pwm period
  logic rise; // command rising edge
  logic low_long; // command low past the idle limit
  logic hi_done; // command high for the initial window
  logic pulse_act; // ramping or holding
  lbps_mode_t mode;
  logic [7:0] rate; // ramp register of active pulse
  logic [7:0] cnt; // pulse register of active pulse
  logic [3:0] rise_n;
  logic [3:0] fall_n;
  logic [4:0] on_total; // on units incl. slow scaling
  logic [4:0] off_total;
  logic p2_en; // second pulse has both times

  // table addressed by the coming step so its data lines up with st.step
  lbps_rom u_rom (
    .CLK(CLK),
    .NRST(NRST),
    .ADDR(next_st.step),
    .DATA(on_us)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    mode = lbps_mode_t'(st.ctrl[1:0]);
    rate = st.sel2 ? st.ramp2 : st.ramp1;
    cnt = st.sel2 ? st.second_pulse : st.first_pulse;
    rise_n = rate[HI_NIB +: 4];
    fall_n = rate[3:0];
    // slow bit doubles the unit count
    on_total = st.ctrl[SLOW_BIT] ? {cnt[HI_NIB +: 4], 1'b0} : {1'b0, cnt[HI_NIB +: 4]};
    off_total = st.ctrl[SLOW_BIT] ? {cnt[3:0], 1'b0} : {1'b0, cnt[3:0]};
    p2_en = (st.second_pulse[HI_NIB +: 4] != 4'h0) && (st.second_pulse[3:0] != 4'h0);
    rise = st.cmd_sync && !st.cmd_prev;
    low_long = (st.low_cnt == LOW_IDLE_CYC_P);
    hi_done = (st.hi_cnt == INIT_PULSE_CYC_P);
    pulse_act = (st.state == S_RISE) || (st.state == S_ON) || (st.state == S_FALL);

    // synchronisers, two stages each
    next_st.cmd_meta = CMD_IN;
    next_st.cmd_sync = st.cmd_meta;
    next_st.cmd_prev = st.cmd_sync;
    next_st.current_set_resistor_meta = CURRENT_SET_RESISTOR_PRESENT;
    next_st.current_set_resistor_sync = st.current_set_resistor_meta;

    // register writes; reserved control bits stay zero
    if (REG_BUS.wr) begin
      case (REG_BUS.addr)
        REG_RAMP1: next_st.ramp1 = REG_BUS.wdata;
        REG_FIRST_PULSE: next_st.first_pulse = REG_BUS.wdata;
        REG_RAMP2: next_st.ramp2 = REG_BUS.wdata;
        REG_SECOND_PULSE: next_st.second_pulse = REG_BUS.wdata;
        REG_CTRL: next_st.ctrl = REG_BUS.wdata & CTRL_WMASK;
        default: next_st.ctrl = st.ctrl; // read-only or unmapped
      endcase
    end
    // register reads, unmapped reads zero
    next_st.rdata = 8'h00;
    if (REG_BUS.rd) begin
      case (REG_BUS.addr)
        REG_RAMP1: next_st.rdata = st.ramp1;
        REG_FIRST_PULSE: next_st.rdata = st.first_pulse;
        REG_RAMP2: next_st.rdata = st.ramp2;
        REG_SECOND_PULSE: next_st.rdata = st.second_pulse;
        REG_CTRL: next_st.rdata = st.ctrl;
        REG_STATUS: next_st.rdata = {st.internal_ref, st.led, st.state != S_IDLE, st.step};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // --------------------------------------------
    // pwm time base: microsecond ticks, 3333 per period
    // --------------------------------------------
    tick = (st.pre_cnt == PWM_TICK_CYC_P - 12'h001);
    period_end = tick && (st.us_cnt == PWM_LAST_US);
    next_st.pre_cnt = tick ? 12'h000 : st.pre_cnt + 12'h001;
    if (tick) begin
      next_st.us_cnt = period_end ? 12'h000 : st.us_cnt + 12'h001;
    end

    // high and low duration counters, saturating
    if (st.cmd_sync) begin
      next_st.low_cnt = 32'h0;
      if (!hi_done) next_st.hi_cnt = st.hi_cnt + 32'h1;
    end else begin
      next_st.hi_cnt = 32'h0;
      if (!low_long) next_st.low_cnt = st.low_cnt + 32'h1;
    end

    // resistor presence caught once, on the first rising edge
    if (rise && !st.first_seen) begin
      next_st.first_seen = 1'b1;
      next_st.internal_ref = !st.current_set_resistor_sync;
    end

    // --------------------------------------------
    // sequencer
    // --------------------------------------------
    case (st.state)
      S_IDLE: begin
        next_st.step = 5'h00;
        next_st.sel2 = 1'b0;
        next_st.init = 1'b0;
        next_st.oneshot = 1'b0;
        next_st.rate_cnt = 4'h0;
        if (rise) begin
          case (mode)
            MODE_DEFAULT: begin
              next_st.init = 1'b1;
              next_st.state = S_RISE;
            end
            MODE_MIRROR: next_st.state = S_MIRROR;
            MODE_REPEAT: next_st.state = S_RISE;
            MODE_ONESHOT: next_st.state = S_ARM;
            default: next_st.state = S_IDLE;
          endcase
        end
      end
      S_MIRROR: begin
        // leaves only when software picks another mode
        if (mode != MODE_MIRROR) next_st.state = S_IDLE;
      end
      S_ARM: begin
        // a glitch shorter than the arming time never starts a pulse
        if (!st.cmd_sync) begin
          next_st.state = S_IDLE;
        end else if (st.hi_cnt >= ARM_HIGH_CYC_P) begin
          next_st.oneshot = 1'b1;
          next_st.state = S_RISE;
        end
      end
      S_RISE: begin
        next_st.tmr = 32'h0;
        next_st.units = 5'h00;
        if (rise_n == 4'h0) begin
          next_st.step = STEP_MAX;
          next_st.state = S_ON;
        end else if (period_end) begin
          if (st.rate_cnt == rise_n - 4'h1) begin
            next_st.rate_cnt = 4'h0;
            next_st.step = st.step + 5'h01;
            if (st.step == STEP_MAX - 5'h01) next_st.state = S_ON;
          end else begin
            next_st.rate_cnt = st.rate_cnt + 4'h1;
          end
        end
      end
      S_ON: begin
        // zero on count falls straight away
        if (st.units == on_total) begin
          next_st.rate_cnt = 4'h0;
          next_st.state = S_FALL;
        end else if (st.tmr == ON_UNIT_CYC_P - 32'h1) begin
          next_st.tmr = 32'h0;
          next_st.units = st.units + 5'h01;
        end else begin
          next_st.tmr = st.tmr + 32'h1;
        end
      end
      S_FALL: begin
        next_st.tmr = 32'h0;
        next_st.units = 5'h00;
        if (fall_n == 4'h0 || (period_end && st.step == 5'h01 &&
            st.rate_cnt == fall_n - 4'h1)) begin
          next_st.step = 5'h00;
          next_st.rate_cnt = 4'h0;
          next_st.state = st.init ? S_WAIT : S_OFF;
        end else if (period_end) begin
          if (st.rate_cnt == fall_n - 4'h1) begin
            next_st.rate_cnt = 4'h0;
            next_st.step = st.step - 5'h01;
          end else begin
            next_st.rate_cnt = st.rate_cnt + 4'h1;
          end
        end
      end
      S_OFF: begin
        if (st.units == off_total) begin
          next_st.tmr = 32'h0;
          next_st.units = 5'h00;
          if (st.oneshot) begin
            // replay only while the command is still high
            next_st.state = st.cmd_sync ? S_RISE : S_IDLE;
          end else begin
            next_st.sel2 = !st.sel2 && p2_en;
            next_st.state = S_RISE;
          end
        end else if (st.tmr == OFF_UNIT_CYC_P - 32'h1) begin
          next_st.tmr = 32'h0;
          next_st.units = st.units + 5'h01;
        end else begin
          next_st.tmr = st.tmr + 32'h1;
        end
      end
      S_WAIT: begin
        // initial pulse done; held command enters the pattern
        if (st.cmd_sync && hi_done) begin
          next_st.init = 1'b0;
          next_st.sel2 = 1'b0;
          next_st.state = S_RISE;
        end else if (low_long) begin
          next_st.state = S_IDLE;
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    // pattern stops on a long low; one-shot and the initial pulse run out
    if (low_long && !st.init && !st.oneshot &&
        (pulse_act || st.state == S_OFF)) begin
      next_st.state = S_IDLE;
    end

    // --------------------------------------------
    // led drive and current range
    // --------------------------------------------
    if (st.state == S_MIRROR) begin
      next_st.led = st.cmd_sync;
    end else begin
      next_st.led = pulse_act && (st.us_cnt < on_us);
    end
    next_st.reduced = pulse_act && (st.step < STEP_REDUCED_LIM);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
      st.ramp1 <= RAMP1_RST;
      st.first_pulse <= FIRST_PULSE_RST;
      st.ramp2 <= RAMP2_RST;
      st.second_pulse <= SECOND_PULSE_RST;
      st.ctrl <= CTRL_RST;
      st.state <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign REG_RDATA = st.rdata;
  assign LED_DRIVE_OUTPUT = st.led;
  assign CURRENT_REDUCED = st.reduced;
  assign FULL_SCALE_CURRENT_SELECT = st.ctrl[ISEL_LSB +: 2];
  assign USE_INTERNAL_REF = st.internal_ref;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_idle_led_off: assert property (st.state == S_IDLE |=> !LED_DRIVE_OUTPUT)
    else $error("led lit while idle");
  a_mirror_follow: assert property (
    st.state == S_MIRROR |=> LED_DRIVE_OUTPUT == $past(st.cmd_sync))
    else $error("mirror led differs from command");
  a_long_low_idle: assert property (
    (st.state == S_OFF || pulse_act) && !st.init && !st.oneshot && low_long
    |=> st.state == S_IDLE)
    else $error("pattern kept running after long low");
  a_mode_decode: assert property (
    st.state == S_IDLE && rise && mode == MODE_MIRROR |=> st.state == S_MIRROR)
    else $error("mirror mode not entered");
  a_oneshot_arm: assert property (
    st.state == S_ARM && st.cmd_sync && st.hi_cnt >= ARM_HIGH_CYC_P
    |=> st.state == S_RISE && st.oneshot && !st.sel2)
    else $error("one-shot did not start first pulse");
  a_oneshot_hold: assert property (
    st.oneshot && pulse_act && !st.cmd_sync |=> st.state != S_IDLE)
    else $error("one-shot pulse cut by command");
  a_zero_rate: assert property (
    st.state == S_RISE && rise_n == 4'h0 |=> st.step == STEP_MAX && st.state == S_ON)
    else $error("zero ramp rate did not jump to full");
  a_full_on: assert property (
    st.state == S_ON ##1 st.state == S_ON |=> LED_DRIVE_OUTPUT)
    else $error("full step not fully on");
  a_reduced_range: assert property (
    st.state == S_RISE && st.step < STEP_REDUCED_LIM |=> CURRENT_REDUCED)
    else $error("low step not at reduced current");
  a_wait_repeat: assert property (
    st.state == S_WAIT && st.cmd_sync && hi_done |=> st.state == S_RISE && !st.init)
    else $error("held command did not enter pattern");
endmodule
